// *** rtl/fsc_core.sv ***
// design: network state gating, task-cycle sync selection and fault reset control
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module fsc_core
  import fsc_pkg::*;
(
  // clock and reset
  input  wire  logic        core_clk_in,
  input  wire  logic        rst_n_in,
  // register port
  input  wire  fsc_bus_t    bus_in,
  output logic [31:0]       rdata_out,
  // network state requests from the link controller
  input  wire  logic        net_req_valid_in,
  input  wire  fsc_net_t    net_req_state_in,
  // sync event pulses and link activity
  input  wire  logic        sys_sync_in,
  input  wire  logic        can_sync_in,
  input  wire  logic        eth_sync_in,
  input  wire  logic        sys_active_in,
  input  wire  logic        eth_active_in,
  // fault cause and acknowledge sources
  input  wire  logic [15:0] ctrl_word_in,
  input  wire  logic        stop_key_in,
  input  wire  logic        ack_input_in,
  input  wire  logic        ack_input_hw_in,
  input  wire  logic        fault_cause_in,
  // outputs
  output fsc_gate_t         gate_out,
  output logic              task_sync_out,
  output logic              fault_out,
  output logic              emcy_zero_out,
  output logic              irq_out
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  fsc_net_t    net_reg;
  logic [7:0]  sel_reg;
  logic [7:0]  act_reg;
  logic [9:0]  ofs_reg;
  logic [2:0]  loc_reg;
  logic        fault_reg;
  logic        cw_ack_reg;
  logic        sys_lock_reg;
  logic        fb_lock_reg;
  logic [7:0]  us_div_reg;
  logic [9:0]  task_us_reg;
  logic [15:0] sys_cyc_reg, sys_pos_reg, sys_cnt_reg;
  logic [15:0] fb_cyc_reg, fb_pos_reg, fb_cnt_reg;
  logic [FSC_IRQ_W-1:0] ist_reg;
  logic [FSC_IRQ_W-1:0] ien_reg;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic src_valid(input logic [7:0] v);
    return (v <= FSC_SRC_ETHSYN) || (v == FSC_SRC_OFF);
  endfunction

  function automatic logic [7:0] resolve_src(input logic [7:0] v,
                                             input logic eth_act,
                                             input logic sys_act);
    if (v != FSC_SRC_AUTO) begin
      return v;
    end
    if (eth_act) begin
      return FSC_SRC_ETHSYN;
    end
    if (sys_act) begin
      return FSC_SRC_SYSBUS;
    end
    return FSC_SRC_OFF;
  endfunction

  logic wr_hit_sel, wr_hit_ofs, wr_hit_loc, wr_hit_cmd, wr_hit_clr, wr_hit_en;
  assign wr_hit_sel = bus_in.wr && (bus_in.addr == FSC_ADDR_SYNC_SEL);
  assign wr_hit_ofs = bus_in.wr && (bus_in.addr == FSC_ADDR_SYNC_OFS);
  assign wr_hit_loc = bus_in.wr && (bus_in.addr == FSC_ADDR_CTRL_LOC);
  assign wr_hit_cmd = bus_in.wr && (bus_in.addr == FSC_ADDR_NET_CMD);
  assign wr_hit_clr = bus_in.wr && (bus_in.addr == FSC_ADDR_IRQ_CLR);
  assign wr_hit_en  = bus_in.wr && (bus_in.addr == FSC_ADDR_IRQ_EN);

  // ----------------------------------------
  // network state machine
  // ----------------------------------------
  // one step at a time upward keeps start-up order; any drop allowed
  function automatic logic net_step_ok(input fsc_net_t cur, input fsc_net_t nxt);
    case (cur)
      FSC_NET_INIT:   return nxt == FSC_NET_PREOP;
      FSC_NET_PREOP:  return nxt inside {FSC_NET_INIT, FSC_NET_SAFEOP};
      FSC_NET_SAFEOP: return nxt != FSC_NET_SAFEOP;
      FSC_NET_OP:     return nxt != FSC_NET_OP;
      default:        return 1'b0;
    endcase
  endfunction

  fsc_net_t net_req;
  logic     net_req_v;
  assign net_req   = wr_hit_cmd ? fsc_net_t'(bus_in.wdata[1:0]) : net_req_state_in;
  assign net_req_v = wr_hit_cmd || net_req_valid_in;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      net_reg <= FSC_NET_INIT;
    end else if (net_req_v && net_step_ok(net_reg, net_req)) begin
      net_reg <= net_req;
    end
  end

  // exchange permits follow the state
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      gate_out <= '0;
    end else begin
      gate_out.sdo_en       <= (net_reg != FSC_NET_INIT);
      gate_out.tx_pdo_en    <= (net_reg == FSC_NET_SAFEOP) ||
                               (net_reg == FSC_NET_OP);
      gate_out.rx_pdo_apply <= (net_reg == FSC_NET_OP);
    end
  end

  // ----------------------------------------
  // sync source selection
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sel_reg <= FSC_SRC_CAN;
    end else if (wr_hit_sel && src_valid(bus_in.wdata[7:0])) begin
      sel_reg <= bus_in.wdata[7:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      act_reg <= FSC_SRC_CAN;
    end else begin
      act_reg <= resolve_src(sel_reg, eth_active_in, sys_active_in);
    end
  end

  // offset writes outside the range are clamped, not refused
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ofs_reg <= FSC_OFS_DEF_US;
    end else if (wr_hit_ofs) begin
      if (bus_in.wdata[31:10] != '0 || bus_in.wdata[9:0] > FSC_OFS_MAX_US) begin
        ofs_reg <= FSC_OFS_MAX_US;
      end else if (bus_in.wdata[9:0] < FSC_OFS_MIN_US) begin
        ofs_reg <= FSC_OFS_MIN_US;
      end else begin
        ofs_reg <= bus_in.wdata[9:0];
      end
    end
  end

  // ----------------------------------------
  // 1 ms task timebase and measurement
  // ----------------------------------------
  logic us_tick;
  assign us_tick = (us_div_reg == FSC_US_CYC);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      us_div_reg  <= '0;
      task_us_reg <= '0;
    end else begin
      us_div_reg <= us_tick ? '0 : us_div_reg + 8'h01;
      if (us_tick) begin
        task_us_reg <= (task_us_reg == FSC_TASK_US) ? '0 : task_us_reg + 10'h001;
      end
    end
  end

  // task sync pulse at the configured point of each task
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      task_sync_out <= 1'b0;
    end else begin
      task_sync_out <= us_tick && (task_us_reg == ofs_reg);
    end
  end

  // the bus period is whole ms multiples; counters only measure it
  logic fb_sync;
  assign fb_sync = (act_reg == FSC_SRC_CAN) ? can_sync_in :
                   ((act_reg == FSC_SRC_ETH) || (act_reg == FSC_SRC_ETHSYN)) ? eth_sync_in :
                   1'b0;

  // a tick on the event edge still belongs to the period ending there,
  // otherwise the reading would slip by one depending on tick phase
  logic [15:0] sys_cnt_now, fb_cnt_now;
  assign sys_cnt_now = sys_cnt_reg + {15'h0000, us_tick && (sys_cnt_reg != FSC_MEAS_MAX)};
  assign fb_cnt_now  = fb_cnt_reg + {15'h0000, us_tick && (fb_cnt_reg != FSC_MEAS_MAX)};

  // period counter saturates instead of wrapping; a lost source keeps its last period in the reading
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sys_cnt_reg <= '0;
      sys_cyc_reg <= '0;
      sys_pos_reg <= '0;
    end else begin
      if (sys_sync_in) begin
        sys_cyc_reg <= sys_cnt_now;
        sys_pos_reg <= {6'h00, task_us_reg};
        sys_cnt_reg <= '0;
      end else begin
        sys_cnt_reg <= sys_cnt_now;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      fb_cnt_reg <= '0;
      fb_cyc_reg <= '0;
      fb_pos_reg <= '0;
    end else begin
      if (fb_sync) begin
        fb_cyc_reg <= fb_cnt_now;
        fb_pos_reg <= {6'h00, task_us_reg};
        fb_cnt_reg <= '0;
      end else begin
        fb_cnt_reg <= fb_cnt_now;
      end
    end
  end

  // lock: source selected, event seen within 1.5 periods; system bus lock also needs sys_active_in
  logic sys_lock_next, fb_lock_next;
  // limit kept one bit wider so long periods cannot wrap it
  assign sys_lock_next = (act_reg == FSC_SRC_SYSBUS) && sys_active_in &&
                         (sys_cyc_reg != '0) &&
                         ({1'b0, sys_cnt_reg} <=
                          {1'b0, sys_cyc_reg} + {2'b00, sys_cyc_reg[15:1]});
  assign fb_lock_next  = ((act_reg == FSC_SRC_CAN) || (act_reg == FSC_SRC_ETH) ||
                          (act_reg == FSC_SRC_ETHSYN)) && (fb_cyc_reg != '0) &&
                         ({1'b0, fb_cnt_reg} <=
                          {1'b0, fb_cyc_reg} + {2'b00, fb_cyc_reg[15:1]});

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sys_lock_reg <= 1'b0;
      fb_lock_reg  <= 1'b0;
    end else begin
      sys_lock_reg <= sys_lock_next;
      fb_lock_reg  <= fb_lock_next;
    end
  end

  // ----------------------------------------
  // fault reset
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      loc_reg <= '0;
    end else if (wr_hit_loc) begin
      loc_reg <= bus_in.wdata[2:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cw_ack_reg <= 1'b0;
    end else begin
      cw_ack_reg <= ctrl_word_in[FSC_CW_ACK_BIT];
    end
  end

  logic ack_cw, ack_key, ack_inp, ack_any;
  assign ack_cw  = loc_reg[FSC_LOC_STATEM] && ctrl_word_in[FSC_CW_ACK_BIT]
                   && !cw_ack_reg;
  assign ack_key = stop_key_in && loc_reg[FSC_LOC_KEYPAD];
  assign ack_inp = ack_input_in &&
                   (loc_reg[FSC_LOC_INPUT] || ack_input_hw_in);
  assign ack_any = fault_reg && (ack_cw || ack_key || ack_inp);

  // a live cause wins over any acknowledge
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      fault_reg <= 1'b0;
    end else if (fault_cause_in) begin
      fault_reg <= 1'b1;
    end else if (ack_any) begin
      fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      fault_out     <= 1'b0;
      emcy_zero_out <= 1'b0;
    end else begin
      fault_out     <= fault_reg;
      emcy_zero_out <= ack_any && !fault_cause_in;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [FSC_IRQ_W-1:0] ev;
  assign ev[FSC_IRQ_FAULT]   = fault_cause_in && !fault_reg;
  assign ev[FSC_IRQ_ACK]     = ack_any && !fault_cause_in;
  assign ev[FSC_IRQ_LOCKCHG] = (sys_lock_next != sys_lock_reg) ||
                               (fb_lock_next != fb_lock_reg);
  assign ev[FSC_IRQ_NETCHG]  = net_req_v && net_step_ok(net_reg, net_req);

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ist_reg <= '0;
      ien_reg <= '0;
    end else begin
      ist_reg <= (ist_reg & ~(wr_hit_clr ? bus_in.wdata[FSC_IRQ_W-1:0] : '0)) | ev;
      if (wr_hit_en) begin
        ien_reg <= bus_in.wdata[FSC_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(ist_reg & ien_reg);
    end
  end

  // ----------------------------------------
  // read port, data one cycle after strobe
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        FSC_ADDR_NET_STATE: rdata_out <= {30'h0, net_reg};
        FSC_ADDR_SYNC_SEL:  rdata_out <= {24'h0, sel_reg};
        FSC_ADDR_SYNC_ACT:  rdata_out <= {24'h0, act_reg};
        FSC_ADDR_SYNC_OFS:  rdata_out <= {22'h0, ofs_reg};
        FSC_ADDR_LOCK:      rdata_out <= {30'h0, fb_lock_reg, sys_lock_reg};
        FSC_ADDR_SYS_MEAS:  rdata_out <= {sys_pos_reg, sys_cyc_reg};
        FSC_ADDR_FB_MEAS:   rdata_out <= {fb_pos_reg, fb_cyc_reg};
        FSC_ADDR_CTRL_LOC:  rdata_out <= {29'h0, loc_reg};
        FSC_ADDR_FAULT:     rdata_out <= {31'h0, fault_reg};
        FSC_ADDR_IRQ_STAT:  rdata_out <= {28'h0, ist_reg};
        FSC_ADDR_IRQ_EN:    rdata_out <= {28'h0, ien_reg};
        default:            rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

endmodule

`default_nettype wire

// *** rtl/fsc_pkg.sv ***
// package: constants, register map and types for fieldbus state/sync/fault control
package fsc_pkg;

  // register byte offsets
  localparam logic [7:0] FSC_ADDR_NET_STATE  = 8'h00;
  localparam logic [7:0] FSC_ADDR_NET_CMD    = 8'h04;
  localparam logic [7:0] FSC_ADDR_SYNC_SEL   = 8'h08;
  localparam logic [7:0] FSC_ADDR_SYNC_ACT   = 8'h0c;
  localparam logic [7:0] FSC_ADDR_SYNC_OFS   = 8'h10;
  localparam logic [7:0] FSC_ADDR_LOCK       = 8'h14;
  localparam logic [7:0] FSC_ADDR_SYS_MEAS   = 8'h18;
  localparam logic [7:0] FSC_ADDR_FB_MEAS    = 8'h1c;
  localparam logic [7:0] FSC_ADDR_CTRL_LOC   = 8'h20;
  localparam logic [7:0] FSC_ADDR_FAULT      = 8'h24;
  localparam logic [7:0] FSC_ADDR_IRQ_STAT   = 8'h28;
  localparam logic [7:0] FSC_ADDR_IRQ_EN     = 8'h2c;
  localparam logic [7:0] FSC_ADDR_IRQ_CLR    = 8'h30;

  // synchronisation source selector codes
  localparam logic [7:0] FSC_SRC_AUTO   = 8'h00;
  localparam logic [7:0] FSC_SRC_CAN    = 8'h01;
  localparam logic [7:0] FSC_SRC_SYSBUS = 8'h02;
  localparam logic [7:0] FSC_SRC_ETH    = 8'h03;
  localparam logic [7:0] FSC_SRC_ETHSYN = 8'h04;
  localparam logic [7:0] FSC_SRC_OFF    = 8'h63;

  // phase offset limits in microseconds
  localparam logic [9:0] FSC_OFS_MIN_US = 10'h2bc;
  localparam logic [9:0] FSC_OFS_MAX_US = 10'h384;
  localparam logic [9:0] FSC_OFS_DEF_US = 10'h320;

  // timing: 200 MHz core clock, one microsecond tick
  localparam int         FSC_CLK_MHZ    = 200;
  localparam int         FSC_US_CYC_I   = FSC_CLK_MHZ;
  localparam logic [7:0] FSC_US_CYC     = 8'(FSC_US_CYC_I - 1);
  localparam int         FSC_TASK_US_I  = 1000;
  localparam logic [9:0] FSC_TASK_US    = 10'(FSC_TASK_US_I - 1);
  localparam logic [15:0] FSC_MEAS_MAX  = 16'hffff;

  // control word acknowledge bit
  localparam int FSC_CW_ACK_BIT = 7;

  // control location bit positions
  localparam int FSC_LOC_STATEM = 0;
  localparam int FSC_LOC_KEYPAD = 1;
  localparam int FSC_LOC_INPUT  = 2;

  // interrupt status bit positions
  localparam int FSC_IRQ_W       = 4;
  localparam int FSC_IRQ_FAULT   = 0;
  localparam int FSC_IRQ_ACK     = 1;
  localparam int FSC_IRQ_LOCKCHG = 2;
  localparam int FSC_IRQ_NETCHG  = 3;

  // network states, gray coded along init -> operational
  typedef enum logic [1:0] {
    FSC_NET_INIT   = 2'b00,
    FSC_NET_PREOP  = 2'b01,
    FSC_NET_SAFEOP = 2'b11,
    FSC_NET_OP     = 2'b10
  } fsc_net_t;

  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fsc_bus_t;

  // exchange permits toward data paths
  typedef struct packed {
    logic sdo_en;
    logic tx_pdo_en;
    logic rx_pdo_apply;
  } fsc_gate_t;

endpackage

// *** test/fsc_core_monitor.sv ***
// checker: concurrent properties on the ports of fsc_core
`timescale 1ns/100ps
`default_nettype none
module fsc_core_monitor
  import fsc_pkg::*;
(
  // clock and reset
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  // observed inputs
  input wire fsc_bus_t    bus_in,
  input wire logic [15:0] ctrl_word_in,
  input wire logic        stop_key_in,
  input wire logic        ack_input_in,
  input wire logic        ack_input_hw_in,
  input wire logic        fault_cause_in,
  // observed outputs
  input wire logic [31:0] rdata_out,
  input wire fsc_gate_t   gate_out,
  input wire logic        task_sync_out,
  input wire logic        fault_out,
  input wire logic        emcy_zero_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [2:0] loc_reg;
  logic       cw7_reg;
  logic       key_ok;
  logic       cw_ok;
  // mirror of control location, which the design keeps out of sight
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      loc_reg <= 3'h0;
    end else if (bus_in.wr && bus_in.addr == FSC_ADDR_CTRL_LOC) begin
      loc_reg <= bus_in.wdata[2:0];
    end
  end
  // previous ack bit, for edge detection
  always_ff @(posedge core_clk_in) begin
    cw7_reg <= rst_n_in & ctrl_word_in[FSC_CW_ACK_BIT];
  end
  // permitted acknowledge paths
  assign key_ok = (stop_key_in && loc_reg[FSC_LOC_KEYPAD]) ||
                  (ack_input_in && (loc_reg[FSC_LOC_INPUT] || ack_input_hw_in));
  assign cw_ok  = ctrl_word_in[FSC_CW_ACK_BIT] && !cw7_reg && loc_reg[FSC_LOC_STATEM];
  sequence s_ack_edge;
    !ctrl_word_in[FSC_CW_ACK_BIT] ##1 ctrl_word_in[FSC_CW_ACK_BIT];
  endsequence
  // zero message one cycle after the ack, fault low the cycle after that
  sequence s_clear_emcy;
    emcy_zero_out ##1 !fault_out;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_in |=>
    gate_out == 3'h0 && !fault_out && !irq_out && !emcy_zero_out && rdata_out == 32'h0)
    else $error("outputs not quiet in reset");
  a_tx_needs_sdo: assert property (gate_out.tx_pdo_en |-> gate_out.sdo_en)
    else $error("process data without service data");
  a_rx_needs_tx: assert property (gate_out.rx_pdo_apply |-> gate_out.tx_pdo_en)
    else $error("rx applied without tx");
  a_op_step_up: assert property ($rose(gate_out.rx_pdo_apply) |-> $past(gate_out.tx_pdo_en))
    else $error("operational entered without safe-op");
  a_rdata_idle: assert property (!$past(bus_in.rd) |-> rdata_out == 32'h0)
    else $error("read data outside read slot");
  // fault_out lags the internal flag by one cycle, so it shows the flag's
  // value at an ack edge one cycle later
  a_cause_sets: assert property (fault_cause_in |-> ##2 fault_out)
    else $error("fault cause did not raise fault");
  a_ack_clears: assert property (s_ack_edge ##0
    (loc_reg[FSC_LOC_STATEM] && !fault_cause_in) ##1 fault_out |-> s_clear_emcy)
    else $error("control word ack did not clear fault");
  a_key_clears: assert property ((key_ok && !fault_cause_in) ##1 fault_out |-> s_clear_emcy)
    else $error("permitted ack did not clear fault");
  a_no_stray: assert property ((!key_ok && !cw_ok) ##1 fault_out |=> fault_out)
    else $error("fault cleared without permitted ack");
  a_sync_pulse: assert property (task_sync_out |=> !task_sync_out)
    else $error("task sync longer than a cycle");
endmodule
bind fsc_core fsc_core_monitor mon (
  .core_clk_in, .rst_n_in, .bus_in, .ctrl_word_in, .stop_key_in, .ack_input_in,
  .ack_input_hw_in, .fault_cause_in, .rdata_out, .gate_out, .task_sync_out,
  .fault_out, .emcy_zero_out, .irq_out
);
`default_nettype wire

// *** test/fsc_master_model.sv ***
// partner: fieldbus master issuing sync events and control word acks
`timescale 1ns/100ps
`default_nettype none
module fsc_master_model
  import fsc_pkg::*;
#(
  parameter int UNIT_US = 1000
) (
  // clock
  input  wire logic        core_clk_in,
  // sync generator control
  input  wire logic        run_in,
  input  wire logic [7:0]  units_in,
  // toward the drive
  output logic             sync_out,
  output logic [15:0]      ctrl_word_out
);
  initial begin
    sync_out = 1'b0;
    ctrl_word_out = 16'h0000;
  end
  // period is a whole number of units; unit shortened by the bench
  always begin
    @(posedge core_clk_in);
    if (run_in) begin
      repeat (int'(units_in) * UNIT_US * FSC_CLK_MHZ - 2) @(posedge core_clk_in);
      sync_out <= 1'b1;
      @(posedge core_clk_in);
      sync_out <= 1'b0;
    end
  end
  // fault acknowledge lives in bit 7 only
  task automatic set_ack(input logic on);
    @(posedge core_clk_in);
    ctrl_word_out <= on ? 16'h0080 : 16'h0000;
  endtask
endmodule
`default_nettype wire

// *** test/fsc_core_bench.sv ***
// testbench: register, network, sync and fault scenarios for fsc_core
`timescale 1ns/100ps
`default_nettype none
module fsc_core_bench;
  import fsc_pkg::*;
  localparam int UNIT_US = 10; // short sync unit keeps the run brief
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  fsc_bus_t    bus = '0;
  logic        nq_v = 1'b0;
  fsc_net_t    nq_s = FSC_NET_INIT;
  logic [1:0]  route = 2'h0;
  logic        sys_act = 1'b0;
  logic        eth_act = 1'b0;
  logic        stop_key = 1'b0;
  logic        ack_in = 1'b0;
  logic        ack_hw = 1'b0;
  logic        cause = 1'b0;
  logic        p_run = 1'b0;
  logic [7:0]  p_units = 8'h01;
  logic        p_sync;
  logic [15:0] cw;
  logic [31:0] rdata;
  fsc_gate_t   gate;
  logic        tsync;
  logic        fault;
  logic        emcy;
  logic        irq;
  int          err_total = 0;
  int          cmp_count = 0;
  int          emcy_n = 0;
  int          tsync_n = 0;
  logic [1:0]  nst [3] = '{2'b01, 2'b11, 2'b10};
  logic [2:0]  ngt [3] = '{3'b100, 3'b110, 3'b111};
  logic [7:0]  scode [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h63};
  logic [9:0]  ofs_w [4] = '{10'h2bc, 10'h384, 10'h258, 10'h3e8};
  logic [9:0]  ofs_e [4] = '{10'h2bc, 10'h384, 10'h2bc, 10'h384};
  always #2.5 clk = ~clk;
  always @(posedge clk) if (emcy) emcy_n <= emcy_n + 1;
  always @(posedge clk) if (tsync) tsync_n <= tsync_n + 1;
  fsc_core DUT (
    .core_clk_in(clk), .rst_n_in(rst_n), .bus_in(bus), .rdata_out(rdata),
    .net_req_valid_in(nq_v), .net_req_state_in(nq_s),
    .sys_sync_in(p_sync && route == 2'h1), .can_sync_in(p_sync && route == 2'h2),
    .eth_sync_in(p_sync && route == 2'h3), .sys_active_in(sys_act),
    .eth_active_in(eth_act), .ctrl_word_in(cw), .stop_key_in(stop_key),
    .ack_input_in(ack_in), .ack_input_hw_in(ack_hw), .fault_cause_in(cause),
    .gate_out(gate), .task_sync_out(tsync), .fault_out(fault),
    .emcy_zero_out(emcy), .irq_out(irq)
  );
  fsc_master_model #(.UNIT_US(UNIT_US)) master (
    .core_clk_in(clk), .run_in(p_run), .units_in(p_units),
    .sync_out(p_sync), .ctrl_word_out(cw)
  );
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    chk_reg(rdata & m, e);
  endtask
  // one-cycle pulse on a fault path input, then let it settle
  task automatic fire(input int k);
    @(posedge clk);
    case (k)
      0: cause <= 1'b1;
      1: stop_key <= 1'b1;
      default: ack_in <= 1'b1;
    endcase
    @(posedge clk);
    {cause, stop_key, ack_in} <= 3'b000;
    repeat (3) @(posedge clk);
  endtask
  task automatic run_sync(input logic [1:0] r, input logic [7:0] u, input logic [7:0] s);
    wr(FSC_ADDR_SYNC_SEL, {24'h0, s});
    @(posedge clk);
    route <= r;
    p_units <= u;
    p_run <= 1'b1;
    repeat (4) @(posedge p_sync);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(FSC_ADDR_NET_STATE, 32'h0);
    chk_reg({29'h0, gate}, 32'h0);
    rd(FSC_ADDR_SYNC_SEL, 32'h1);
    rd(FSC_ADDR_SYNC_ACT, 32'h1);
    rd(FSC_ADDR_SYNC_OFS, 32'h320);
    rd(8'h3c, 32'h0);
    $display("test reset done");
    wr(FSC_ADDR_NET_CMD, 32'h3);
    rd(FSC_ADDR_NET_STATE, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(FSC_ADDR_NET_CMD, {30'h0, nst[i]});
      rd(FSC_ADDR_NET_STATE, {30'h0, nst[i]});
      chk_reg({29'h0, gate}, {29'h0, ngt[i]});
    end
    @(posedge clk);
    nq_v <= 1'b1;
    nq_s <= FSC_NET_PREOP;
    @(posedge clk);
    nq_v <= 1'b0;
    rd(FSC_ADDR_NET_STATE, 32'h1);
    chk_reg({29'h0, gate}, 32'h4);
    $display("test network done");
    for (int i = 0; i < 5; i++) begin
      wr(FSC_ADDR_SYNC_SEL, {24'h0, scode[i]});
      rd(FSC_ADDR_SYNC_ACT, {24'h0, scode[i]});
    end
    wr(FSC_ADDR_SYNC_SEL, 32'h0);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      {eth_act, sys_act} <= 2'(k);
      repeat (2) @(posedge clk);
      rd(FSC_ADDR_SYNC_ACT, k[1] ? 32'h4 : (k[0] ? 32'h2 : 32'h63));
    end
    wr(FSC_ADDR_SYNC_SEL, 32'h5);
    rd(FSC_ADDR_SYNC_SEL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(FSC_ADDR_SYNC_OFS, {22'h0, ofs_w[i]});
      rd(FSC_ADDR_SYNC_OFS, {22'h0, ofs_e[i]});
    end
    $display("test selector done");
    run_sync(2'h1, 8'h1, FSC_SRC_SYSBUS);
    rd(FSC_ADDR_LOCK, 32'h1);
    rd(FSC_ADDR_SYS_MEAS, 32'(UNIT_US), 32'hffff);
    run_sync(2'h2, 8'h2, FSC_SRC_CAN);
    rd(FSC_ADDR_LOCK, 32'h2);
    rd(FSC_ADDR_FB_MEAS, 32'(2 * UNIT_US), 32'hffff);
    run_sync(2'h3, 8'h1, FSC_SRC_ETH);
    rd(FSC_ADDR_LOCK, 32'h2);
    @(posedge clk);
    p_run <= 1'b0;
    repeat (8 * UNIT_US * FSC_CLK_MHZ) @(posedge clk);
    rd(FSC_ADDR_LOCK, 32'h0);
    $display("test lock done");
    wr(FSC_ADDR_IRQ_CLR, 32'hf);
    wr(FSC_ADDR_IRQ_EN, 32'h1);
    fire(0);
    chk_pin(fault, 1'b1);
    chk_pin(irq, 1'b1);
    rd(FSC_ADDR_IRQ_STAT, 32'h1);
    fire(1);
    chk_pin(fault, 1'b1);
    fire(2);
    chk_pin(fault, 1'b1);
    ack_hw <= 1'b1;
    fire(2);
    chk_pin(fault, 1'b0);
    chk_reg(32'(emcy_n), 32'h1);
    fire(0);
    wr(FSC_ADDR_CTRL_LOC, 32'h2);
    fire(1);
    chk_pin(fault, 1'b0);
    fire(0);
    wr(FSC_ADDR_CTRL_LOC, 32'h1);
    master.set_ack(1'b1);
    repeat (3) @(posedge clk);
    chk_pin(fault, 1'b0);
    chk_reg(32'(emcy_n), 32'h3);
    fire(0);
    chk_pin(fault, 1'b1);
    master.set_ack(1'b0);
    cause <= 1'b1;
    master.set_ack(1'b1);
    repeat (3) @(posedge clk);
    chk_pin(fault, 1'b1);
    cause <= 1'b0;
    wr(FSC_ADDR_IRQ_EN, 32'h0);
    repeat (2) @(negedge clk);
    chk_pin(irq, 1'b0);
    wr(FSC_ADDR_IRQ_CLR, 32'hf);
    rd(FSC_ADDR_IRQ_STAT, 32'h0);
    $display("test fault done");
    // whole run is shorter than the earliest sync point after reset
    chk_reg(32'(tsync_n), 32'h0);
    print_verdict();
  end
  // watchdog: the tests need about 50000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
